// >>> core/gpio_port_with_pin_mux.sv
`timescale 1ns/1ns
// Functional notes
// - each pin connects to its selected peripheral function or to GPIO control
// - pins not given to a peripheral are driven and sensed by GPIO registers
// - every bit has its own direction, changeable at run time
// - one write sets or clears any subset of output bits, others kept
// - one write loads the whole output value
// - every pin can interrupt on level, rising, falling or both edges
// - after reset pins are inputs with pull-up, except two-wire pins
// - each pin except two-wire pins has programmable pull-up or pull-down
// - twelve-bit port, per-bit direction and function select
module gpio_port_with_pin_mux #(
    parameter int PORT_W = gpio_mux_pkg::PORT_W
) (
    // clock and reset
    input  wire logic                                     clock,
    input  wire logic                                     rst_n,
    // configuration write port
    input  wire gpio_mux_pkg::cfg_wr_t                    cfg_wr,
    input  wire logic [PORT_W-1:0][gpio_mux_pkg::FUNC_W-1:0] func_sel,
    // status
    output logic      [PORT_W-1:0]                        port_rd_data,
    output logic      [PORT_W-1:0]                        irq_status,
    output logic      [PORT_W-1:0]                        irq_line,
    // peripheral side
    input  wire logic [gpio_mux_pkg::PERIPH_N-1:0][PORT_W-1:0] periph_out,
    input  wire logic [gpio_mux_pkg::PERIPH_N-1:0][PORT_W-1:0] periph_oe,
    output logic      [gpio_mux_pkg::PERIPH_N-1:0][PORT_W-1:0] periph_in,
    // pads
    input  wire logic [PORT_W-1:0]                        pin_in,
    output logic      [PORT_W-1:0]                        pin_out,
    output logic      [PORT_W-1:0]                        pin_oe,
    output logic      [PORT_W-1:0]                        pull_up_en,
    output logic      [PORT_W-1:0]                        pull_dn_en
);
    // write data, pull masks and interrupt fields are all twelve bits wide
    if (PORT_W != gpio_mux_pkg::PORT_W) begin
        $error("port width must be 12");
    end

    logic [PORT_W-1:0] pin_level;
    logic [PORT_W-1:0] out_reg,    out_next;
    logic [PORT_W-1:0] dir_reg,    dir_next;
    logic [PORT_W-1:0] pu_reg,     pu_next;
    logic [PORT_W-1:0] pd_reg,     pd_next;
    logic [PORT_W-1:0] prev_reg,   prev_next;
    logic [PORT_W-1:0] stat_reg,   stat_next;
    logic [PORT_W-1:0] rd_reg,     rd_next;
    gpio_mux_pkg::irq_cfg_t icfg_reg, icfg_next;
    logic [PORT_W-1:0] rise, fall, edge_evt, level_evt, clr_mask;

    function automatic logic is_gpio(input logic [gpio_mux_pkg::FUNC_W-1:0] f);
        is_gpio = (f == gpio_mux_pkg::FUNC_GPIO);
    endfunction

    function automatic logic wr_hit(input gpio_mux_pkg::cfg_wr_t w,
                                    input gpio_mux_pkg::wr_sel_t s);
        wr_hit = w.en && (w.sel == s);
    endfunction

    pin_sync #(
        .W (PORT_W)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (pin_in),
        .sync_out (pin_level)
    );

    // output, direction and pull configuration
    always_comb begin
        out_next = out_reg;
        dir_next = dir_reg;
        pu_next  = pu_reg;
        pd_next  = pd_reg;
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_ALL)) begin
            out_next = cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_SET)) begin
            out_next = out_reg | cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_CLR)) begin
            out_next = out_reg & ~cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_DIR)) begin
            dir_next = cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_PULL_UP)) begin
            pu_next = cfg_wr.data & ~gpio_mux_pkg::TW_MASK;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_PULL_DN)) begin
            pd_next = cfg_wr.data & ~gpio_mux_pkg::TW_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= gpio_mux_pkg::OUT_RST;
            dir_reg <= gpio_mux_pkg::DIR_RST;
            pu_reg  <= gpio_mux_pkg::PULLUP_RST;
            pd_reg  <= gpio_mux_pkg::PULLDN_RST;
        end else begin
            out_reg <= out_next;
            dir_reg <= dir_next;
            pu_reg  <= pu_next;
            pd_reg  <= pd_next;
        end
    end

    // interrupt sensing; a new event beats a clear in the same cycle
    always_comb begin
        icfg_next = icfg_reg;
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_IRQ_LEVEL)) begin
            icfg_next.level = cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_IRQ_BOTH)) begin
            icfg_next.both = cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_IRQ_POL)) begin
            icfg_next.pol = cfg_wr.data;
        end
        if (wr_hit(cfg_wr, gpio_mux_pkg::SEL_IRQ_EN)) begin
            icfg_next.en = cfg_wr.data;
        end
        clr_mask  = wr_hit(cfg_wr, gpio_mux_pkg::SEL_IRQ_CLR) ? cfg_wr.data : '0;
        prev_next = pin_level;
        rise      = pin_level & ~prev_reg;
        fall      = ~pin_level & prev_reg;
        edge_evt  = ~icfg_reg.level
                  & ((icfg_reg.both & (rise | fall))
                  | (~icfg_reg.both & ((icfg_reg.pol & rise) | (~icfg_reg.pol & fall))));
        level_evt = icfg_reg.level & ~(pin_level ^ icfg_reg.pol);
        stat_next = (stat_reg & ~clr_mask & ~icfg_reg.level) | edge_evt | level_evt;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            icfg_reg <= '0;
            prev_reg <= '0;
            stat_reg <= gpio_mux_pkg::IRQ_RST;
        end else begin
            icfg_reg <= icfg_next;
            prev_reg <= prev_next;
            stat_reg <= stat_next;
        end
    end

    // read-back: input bits show sampled pins, output bits the output register value
    always_comb begin
        rd_next = (dir_reg & out_reg) | (~dir_reg & pin_level);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= rd_next;
        end
    end

    // pin multiplexer
    always_comb begin
        pin_out   = '0;
        pin_oe    = '0;
        periph_in = '0;
        for (int i = 0; i < PORT_W; i++) begin
            if (is_gpio(func_sel[i])) begin
                pin_out[i] = out_reg[i];
                pin_oe[i]  = dir_reg[i];
            end else begin
                for (int k = 0; k < gpio_mux_pkg::PERIPH_N; k++) begin
                    if (int'(func_sel[i]) == k + 1) begin
                        pin_out[i]      = periph_out[k][i];
                        pin_oe[i]       = periph_oe[k][i];
                        periph_in[k][i] = pin_level[i];
                    end
                end
            end
            if (gpio_mux_pkg::TW_MASK[i]) begin
                // open-drain: only ever pull low
                pin_oe[i]  = pin_oe[i] & ~pin_out[i];
                pin_out[i] = 1'b0;
            end
        end
    end

    assign port_rd_data = rd_reg;
    assign irq_status   = stat_reg;
    assign irq_line     = stat_reg & icfg_reg.en;
    assign pull_up_en   = pu_reg;
    assign pull_dn_en   = pd_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence set_write_s;
        wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_SET) && !wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_CLR);
    endsequence

    out_set_a: assert property (
        set_write_s |=> ((out_reg & $past(cfg_wr.data)) == $past(cfg_wr.data))
            && ((out_reg & ~$past(cfg_wr.data)) == ($past(out_reg) & ~$past(cfg_wr.data))))
        else $error("set write lost or disturbed bits");
    out_clr_a: assert property (
        wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_CLR)
            |=> out_reg == ($past(out_reg) & ~$past(cfg_wr.data)))
        else $error("clear write wrong");
    out_all_a: assert property (
        wr_hit(cfg_wr, gpio_mux_pkg::SEL_OUT_ALL) && !cfg_wr.sel[1]
            |=> out_reg == $past(cfg_wr.data))
        else $error("whole port write wrong");
    tw_pull_a: assert property (
        (pull_up_en & gpio_mux_pkg::TW_MASK) == '0
            && (pull_dn_en & gpio_mux_pkg::TW_MASK) == '0)
        else $error("pull enabled on two-wire pin");
    pull_hold_a: assert property (
        !(cfg_wr.en && cfg_wr.sel == gpio_mux_pkg::SEL_PULL_UP) |=> $stable(pull_up_en))
        else $error("pull-up changed without write");
    gpio_dir_a: assert property (
        is_gpio(func_sel[0]) |-> pin_oe[0] == dir_reg[0] && pin_out[0] == out_reg[0])
        else $error("gpio pin not under port control");
    read_in_a: assert property (
        1'b1 |=> ((port_rd_data & ~$past(dir_reg)) == ($past(pin_level) & ~$past(dir_reg))))
        else $error("read value not sampled pin");
    edge_irq_a: assert property (
        1'b1 |=> ((irq_status & $past(edge_evt)) == $past(edge_evt)))
        else $error("edge event not latched");
    level_irq_a: assert property (
        1'b1 |=> ((irq_status & $past(icfg_reg.level)) == $past(level_evt)))
        else $error("level flag does not follow pin");
    mux_periph_a: assert property (
        func_sel[0] == 2'h1 |-> pin_out[0] == periph_out[0][0]
            && periph_in[0][0] == pin_level[0])
        else $error("peripheral not routed");
endmodule

// >>> core/gpio_mux_pkg.sv
package gpio_mux_pkg;

    // port shape
    localparam int              PORT_W      = 12;
    localparam int              FUNC_W      = 2;
    localparam int              PERIPH_N    = 3;

    // positions of the two-wire bus pins within the port
    localparam int              TW_CLK_BIT  = 4;
    localparam int              TW_DAT_BIT  = 5;
    localparam logic [11:0]     TW_MASK     = 12'h030;

    // function select codes
    localparam logic [1:0]      FUNC_GPIO   = 2'h0;

    // reset values
    localparam logic [11:0]     DIR_RST     = 12'h000;
    localparam logic [11:0]     OUT_RST     = 12'h000;
    localparam logic [11:0]     PULLUP_RST  = 12'hfcf;
    localparam logic [11:0]     PULLDN_RST  = 12'h000;
    localparam logic [11:0]     IRQ_RST     = 12'h000;

    typedef enum logic [3:0] {
        SEL_OUT_ALL,
        SEL_OUT_SET,
        SEL_OUT_CLR,
        SEL_DIR,
        SEL_PULL_UP,
        SEL_PULL_DN,
        SEL_IRQ_LEVEL,
        SEL_IRQ_BOTH,
        SEL_IRQ_POL,
        SEL_IRQ_EN,
        SEL_IRQ_CLR
    } wr_sel_t;

    typedef struct packed {
        logic        en;
        wr_sel_t     sel;
        logic [11:0] data;
    } cfg_wr_t;

    typedef struct packed {
        logic [11:0] level;
        logic [11:0] both;
        logic [11:0] pol;
        logic [11:0] en;
    } irq_cfg_t;

endpackage

// >>> core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

// >>> testbench/pin_partner.sv
`timescale 1ns/1ns
module pin_partner #(
    parameter int W = 12
) (
    // clock
    input  wire logic         clock,
    // device pads
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pull_up_en,
    input  wire logic [W-1:0] pull_dn_en,
    // external drivers
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    // resolved wire levels
    output logic      [W-1:0] pin_in
);
    logic [W-1:0] float_reg;

    initial float_reg = {(W/2){2'b01}};
    // a line nobody drives or pulls wanders every cycle
    always @(posedge clock) begin
        float_reg <= ~float_reg;
    end

    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pull_up_en | (~pull_dn_en & float_reg)));
endmodule

// >>> testbench/test_gpio_port_with_pin_mux.sv
`timescale 1ns/1ns
module test_gpio_port_with_pin_mux;
    localparam int          DLY = 1;
    localparam logic [11:0] TW  = gpio_mux_pkg::TW_MASK;
    logic                   clock;
    logic                   rst_n;
    gpio_mux_pkg::cfg_wr_t  cfg_wr;
    logic [11:0][1:0]       func_sel;
    logic [2:0][11:0]       periph_out, periph_oe, periph_in;
    logic [11:0]            port_rd_data, irq_status, irq_line, pin_in, pin_out, pin_oe;
    logic [11:0]            pull_up_en, pull_dn_en, ext_val, ext_en;
    logic [2:0]             mode [4] = '{3'b001, 3'b000, 3'b010, 3'b101};
    logic [3:0]             exp_rise = 4'b1101;
    logic [3:0]             exp_fall = 4'b0110;
    int                     err_total;
    int                     n_compared;

    gpio_port_with_pin_mux gpio_port_with_pin_mux_i (
        .clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .func_sel(func_sel),
        .port_rd_data(port_rd_data), .irq_status(irq_status), .irq_line(irq_line),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));

    pin_partner pin_partner_i (
        .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #DLY;
    endtask

    // one write, then an idle cycle so the strobe is never re-driven in one step
    task automatic wr(input gpio_mux_pkg::wr_sel_t sel, input logic [11:0] data);
        cfg_wr = '{1'b1, sel, data};
        cyc(1);
        cfg_wr.en = 1'b0;
        cyc(1);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #(40 * 2000);
        err_total++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        cfg_wr = '0;
        func_sel = '0;
        periph_out = '0;
        periph_oe = '0;
        ext_val = '0;
        ext_en = '0;
        err_total = 0;
        n_compared = 0;
        repeat (20) @(posedge clock);
        #DLY rst_n = 1'b1;
        check(pull_up_en, gpio_mux_pkg::PULLUP_RST);
        check(pull_dn_en, 12'h000);
        check(pin_oe, 12'h000);
        cyc(4);
        check(port_rd_data & ~TW, 12'hfcf);
        wr(gpio_mux_pkg::SEL_DIR, 12'hfcf);
        wr(gpio_mux_pkg::SEL_OUT_ALL, 12'ha5a);
        check(pin_oe, 12'hfcf);
        check(pin_out & ~TW, 12'ha4a);
        wr(gpio_mux_pkg::SEL_OUT_SET, 12'h005);
        wr(gpio_mux_pkg::SEL_OUT_CLR, 12'ha00);
        check(pin_out & ~TW, 12'h04f);
        cyc(3);
        check(port_rd_data & ~TW, 12'h04f);
        ext_val = 12'h9c0;
        ext_en = 12'hfc0;
        wr(gpio_mux_pkg::SEL_DIR, 12'h00f);
        check(pin_oe, 12'h00f);
        cyc(4);
        check(port_rd_data & ~TW, 12'h9cf);
        wr(gpio_mux_pkg::SEL_PULL_UP, 12'h000);
        wr(gpio_mux_pkg::SEL_PULL_DN, 12'hfff);
        check(pull_up_en, 12'h000);
        check(pull_dn_en, 12'hfcf);
        func_sel[0] = 2'h1;
        func_sel[8] = 2'h3;
        func_sel[2] = 2'h2;
        cyc(1);
        periph_oe[0][0] = 1'b1;
        periph_oe[1][2] = 1'b1;
        ext_val[8] = 1'b1;
        cyc(4);
        check(pin_out & 12'h007, 12'h002);
        check(pin_oe & 12'h007, 12'h007);
        check(periph_in[2] & 12'h100, 12'h100);
        check(periph_in[0] & 12'h100, 12'h000);
        wr(gpio_mux_pkg::SEL_IRQ_EN, 12'h200);
        for (int i = 0; i < 4; i++) begin
            ext_val[9] = 1'b0;
            wr(gpio_mux_pkg::SEL_IRQ_LEVEL, mode[i][2] ? 12'h200 : 12'h000);
            wr(gpio_mux_pkg::SEL_IRQ_BOTH, mode[i][1] ? 12'h200 : 12'h000);
            wr(gpio_mux_pkg::SEL_IRQ_POL, mode[i][0] ? 12'h200 : 12'h000);
            cyc(4);
            wr(gpio_mux_pkg::SEL_IRQ_CLR, 12'h200);
            check(irq_status & 12'h200, 12'h000);
            ext_val[9] = 1'b1;
            cyc(4);
            check(irq_status & 12'h200, exp_rise[i] ? 12'h200 : 12'h000);
            check(irq_line & 12'h200, exp_rise[i] ? 12'h200 : 12'h000);
            wr(gpio_mux_pkg::SEL_IRQ_CLR, 12'h200);
            ext_val[9] = 1'b0;
            cyc(4);
            check(irq_status & 12'h200, exp_fall[i] ? 12'h200 : 12'h000);
        end
        func_sel = '0;
        periph_oe = '0;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        check(pull_up_en, gpio_mux_pkg::PULLUP_RST);
        check(pull_dn_en, 12'h000);
        check(pin_oe, 12'h000);
        check(irq_status, gpio_mux_pkg::IRQ_RST);
        cyc(4);
        check(port_rd_data & ~TW, 12'h9cf);
        report_and_stop();
    end
endmodule
